//--- verilog/flcs_consts.svh
`ifndef FLCS_CONSTS_SVH
`define FLCS_CONSTS_SVH

// ==================================================
// clock and timing
`define FLCS_CLK_MHZ        25
`define FLCS_PROG_TIME_NS   5000
`define FLCS_ERASE_TIME_NS  9000
`define FLCS_PROG_CYC       ((`FLCS_PROG_TIME_NS * `FLCS_CLK_MHZ + 999) / 1000)
`define FLCS_ERASE_CYC      ((`FLCS_ERASE_TIME_NS * `FLCS_CLK_MHZ + 999) / 1000)
`define FLCS_CNT_W          8

// ==================================================
// fuse high byte fields and default
`define FLCS_FH_DEBUG       7
`define FLCS_FH_SPROG       5
`define FLCS_FH_EEPROM_PRESERVE_FUSE      3
`define FLCS_FH_BOOTSZ_HI   2
`define FLCS_FH_BOOTSZ_LO   1
`define FLCS_FH_RESET       8'h99
`define FLCS_FH_SPROG_MASK  8'h20

// ==================================================
// fuse low byte default and lock byte
`define FLCS_FL_RESET       8'he1
`define FLCS_LOCK_RESET     8'hff
`define FLCS_LK_BOOT_UPPER  5
`define FLCS_LK_BOOT_LOWER  4
`define FLCS_LK_MEM_FIRST   0

// ==================================================
// boot section start word addresses per boot size code
`define FLCS_BOOT_START_0   14'h3000
`define FLCS_BOOT_START_1   14'h3800
`define FLCS_BOOT_START_2   14'h3c00
`define FLCS_BOOT_START_3   14'h3e00

// ==================================================
// page geometry
`define FLCS_PC_MSB         13
`define FLCS_PC_PAGE_LSB    6
`define FLCS_PC_WORD_MSB    5
`define FLCS_EE_MSB         9
`define FLCS_EE_PAGE_LSB    2
`define FLCS_EE_BYTE_MSB    1

// ==================================================
// action select and command codes
`define FLCS_XA_ADDR        2'h0
`define FLCS_XA_DATA        2'h1
`define FLCS_XA_CMD         2'h2
`define FLCS_CMD_ERASE      8'h80
`define FLCS_CMD_WR_FUSE    8'h40
`define FLCS_CMD_WR_LOCK    8'h20
`define FLCS_CMD_WR_FLASH   8'h10
`define FLCS_CMD_WR_EE      8'h11
`define FLCS_CMD_RD_SIG     8'h08
`define FLCS_CMD_RD_FUSE    8'h04
`define FLCS_CMD_RD_FLASH   8'h02
`define FLCS_CMD_RD_EE      8'h03

// ==================================================
// read values and pin vector layout
`define FLCS_BLOCKED_DATA   16'hffff
`define FLCS_PAD_BYTE       8'hff
`define FLCS_SIG_LAST       2'h2
`define FLCS_PIN_W          16
`define FLCS_P_MODE         0
`define FLCS_P_SERIAL       1
`define FLCS_P_STROBE       2
`define FLCS_P_XA_HI        3
`define FLCS_P_XA_LO        4
`define FLCS_P_BS1          5
`define FLCS_P_WR_N         6
`define FLCS_P_OE_N         7
`define FLCS_P_DATA_LSB     8
`define FLCS_P_DATA_MSB     15

`endif

//--- verilog/flcs_pkg.sv
`include "flcs_consts.svh"

package flcs_pkg;

   // ==================================================
   // programmer engine state
   typedef enum logic [0:0] {
      flcs_st_idle = 1'b0,
      flcs_st_busy = 1'b1
   } flcs_pst_t;

   // ==================================================
   // pin synchroniser state
   typedef struct packed {
      logic [`FLCS_PIN_W-1:0] s1;
      logic [`FLCS_PIN_W-1:0] s2;
      logic [`FLCS_PIN_W-1:0] s3;
   } flcs_sync_t;

   // ==================================================
   // main block state
   typedef struct packed {
      flcs_pst_t              pst;
      logic [`FLCS_CNT_W-1:0] cnt;
      logic [7:0]             cmd;
      logic [7:0]             addr_lo;
      logic [7:0]             addr_hi;
      logic [7:0]             data_lo;
      logic [7:0]             data_hi;
      logic [7:0]             nv_fh;
      logic [7:0]             nv_fl;
      logic [7:0]             lock;
      logic [7:0]             lat_fh;
      logic [7:0]             lat_fl;
      logic                   pm_d;
      logic                   cap_pend;
      logic [7:0]             osc_cal;
      logic [7:0]             rd_data;
      logic                   rd_oe;
      logic                   store_ok;
      logic                   store_ref;
      logic                   load_done;
      logic [15:0]            load_data;
      logic                   irq_sup;
      logic [7:0]             fl_page;
      logic [5:0]             fl_word;
      logic [7:0]             ee_page;
      logic [1:0]             ee_byte;
      logic                   eeprom_preserve_fuse;
   } flcs_state_t;

endpackage : flcs_pkg

//--- verilog/flcs_pin_sync.sv
`include "flcs_consts.svh"

module flcs_pin_sync
   import flcs_pkg::*;
(
   // clock and reset
   input  wire logic                   clock_in,
   input  wire logic                   rst_in,
   // raw pins
   input  wire logic [`FLCS_PIN_W-1:0] pins_in,
   // synchronised levels and edges
   output logic      [`FLCS_PIN_W-1:0] level_out,
   output logic      [`FLCS_PIN_W-1:0] rise_out,
   output logic      [`FLCS_PIN_W-1:0] fall_out
);

   // reset to the idle pin levels so that no false strobe edge follows reset
   localparam logic [`FLCS_PIN_W-1:0] PIN_IDLE =
      `FLCS_PIN_W'((1 << `FLCS_P_WR_N) | (1 << `FLCS_P_OE_N));

   flcs_sync_t r_ff;
   flcs_sync_t nxt_r;

   // ==================================================
   // two stages, then a third for edge detection
   always_comb begin
      nxt_r    = r_ff;
      nxt_r.s1 = pins_in;
      nxt_r.s2 = r_ff.s1;
      nxt_r.s3 = r_ff.s2;
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         r_ff <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign level_out = r_ff.s2;
   assign rise_out  = r_ff.s2 & ~r_ff.s3;
   assign fall_out  = ~r_ff.s2 & r_ff.s3;

endmodule : flcs_pin_sync

//--- verilog/flcs_fuse_lock_store.sv
// Notes on behaviour
// - both boot lock bits unprogrammed: stores and loads to boot section unrestricted
// - boot lock mode 2: every store into the boot section is refused
// - mode 3: boot stores refused, application code cannot load boot section
// - mode 4: boot stores allowed, application code cannot load boot section
// - modes 3 and 4 with vectors in application: no interrupts inside boot
// - fuse and lock bits read 0 when programmed, 1 when unprogrammed
// - high fuse byte layout and defaults: debug, jtag, serial, osc, eeprom, boot
// - low fuse byte layout and defaults: brown-out, start-up, clock source
// - serial-programming fuse cannot be changed while in serial programming mode
// - programmed debug fuse keeps clock parts running in all sleep modes
// - chip erase leaves both fuse bytes unchanged
// - fuse writes refused once the first memory lock bit is programmed
// - fuses latched on programming entry; changes act after programming mode exits
// - eeprom preserve fuse acts immediately once programmed
// - fuses also latched at power-up in normal mode
// - three signature bytes at addresses 0 to 2, readable even when locked
// - four calibration bytes in high byte of signature addresses 0 to 3
// - reset loads the 1 MHz calibration byte into the oscillator calibration register
// - flash: 256 pages of 64 words, page pc 13:6, word pc 5:0
// - eeprom: 256 pages of 4 bytes, page address 9:2, byte address 1:0
// - strobe pulse loads per action select; write/read strobes run loaded command
// - action select: 00 address, 01 data, 10 command, 11 idle; byte select
// - command byte encodings for erase, writes and reads
// - ready/busy low during an operation, high when a command can be accepted
`include "flcs_consts.svh"

module flcs_fuse_lock_store
   import flcs_pkg::*;
#(
   parameter logic [7:0] SIG_B0   = 8'h5a, // arbitrary value
   parameter logic [7:0] SIG_B1   = 8'h3c, // arbitrary value
   parameter logic [7:0] SIG_B2   = 8'h01, // arbitrary value
   parameter logic [7:0] CAL_1MHZ = 8'h80,
   parameter logic [7:0] CAL_2MHZ = 8'h80,
   parameter logic [7:0] CAL_4MHZ = 8'h80,
   parameter logic [7:0] CAL_8MHZ = 8'h80
) (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // core program memory access
   input  wire logic        core_store_req_in,
   input  wire logic        core_load_req_in,
   input  wire logic [13:0] core_addr_in,
   input  wire logic [13:0] core_pc_in,
   input  wire logic [15:0] mem_rdata_in,
   input  wire logic        vectors_in_app_in,
   output logic             store_grant_out,
   output logic             store_refused_out,
   output logic             load_done_out,
   output logic      [15:0] load_data_out,
   output logic             irq_suppress_out,
   // page geometry
   input  wire logic [9:0]  core_ee_addr_in,
   output logic      [7:0]  flash_page_out,
   output logic      [5:0]  flash_word_out,
   output logic      [7:0]  ee_page_out,
   output logic      [1:0]  ee_byte_out,
   // working fuse values and oscillator calibration
   output logic      [7:0]  fuse_high_config_byte_out,
   output logic      [7:0]  fuse_low_config_byte_out,
   output logic             eeprom_preserve_out,
   output logic             debug_clock_keep_out,
   input  wire logic        osc_cal_wr_in,
   input  wire logic [7:0]  osc_cal_wdata_in,
   output logic      [7:0]  osc_calibration_register_out,
   // parallel programmer pins
   input  wire logic        prog_mode_in,
   input  wire logic        serial_mode_in,
   input  wire logic        load_strobe_pin_in,
   input  wire logic        action_select_hi_in,
   input  wire logic        action_select_lo_in,
   input  wire logic        byte_select_first_in,
   input  wire logic        wr_n_in,
   input  wire logic        oe_n_in,
   input  wire logic [7:0]  prog_data_in,
   output logic      [7:0]  prog_data_out,
   output logic             prog_data_oe_out,
   output logic             ready_busy_out
);

   localparam flcs_state_t ST_RESET = '{
      pst:      flcs_st_idle,
      nv_fh:    `FLCS_FH_RESET,
      nv_fl:    `FLCS_FL_RESET,
      lock:     `FLCS_LOCK_RESET,
      lat_fh:   `FLCS_FH_RESET,
      lat_fl:   `FLCS_FL_RESET,
      cap_pend: 1'b1,
      osc_cal:  CAL_1MHZ,
      eeprom_preserve_fuse:   1'b1,
      default:  '0
   };
   localparam logic [`FLCS_CNT_W-1:0] PROG_CNT  = `FLCS_CNT_W'(`FLCS_PROG_CYC - 1);
   localparam logic [`FLCS_CNT_W-1:0] ERASE_CNT = `FLCS_CNT_W'(`FLCS_ERASE_CYC - 1);

   flcs_state_t             r_ff;
   flcs_state_t             nxt_r;
   logic [`FLCS_PIN_W-1:0]  pin_lvl;
   logic [`FLCS_PIN_W-1:0]  pin_rise;
   logic [`FLCS_PIN_W-1:0]  pin_fall;
   logic [13:0]             boot_start;
   logic                    tgt_boot;
   logic                    pc_boot;
   logic                    store_block;
   logic                    load_block;
   logic                    pm;
   logic [7:0]              pdata;
   logic                    bs1;
   logic                    wr_go;

   // ==================================================
   // programmer pin synchroniser
   flcs_pin_sync u_sync (
      .clock_in  (clock_in),
      .rst_in    (rst_in),
      .pins_in   ({prog_data_in, oe_n_in, wr_n_in, byte_select_first_in,
                   action_select_lo_in, action_select_hi_in, load_strobe_pin_in,
                   serial_mode_in, prog_mode_in}),
      .level_out (pin_lvl),
      .rise_out  (pin_rise),
      .fall_out  (pin_fall)
   );

   assign pm    = pin_lvl[`FLCS_P_MODE];
   assign pdata = pin_lvl[`FLCS_P_DATA_MSB:`FLCS_P_DATA_LSB];
   assign bs1   = pin_lvl[`FLCS_P_BS1];
   assign wr_go = pm & pin_fall[`FLCS_P_WR_N] & (r_ff.pst == flcs_st_idle);

   // ==================================================
   // boot section bounds and lock decisions
   always_comb begin
      unique case (r_ff.lat_fh[`FLCS_FH_BOOTSZ_HI:`FLCS_FH_BOOTSZ_LO])
         2'h0: boot_start = `FLCS_BOOT_START_0;
         2'h1: boot_start = `FLCS_BOOT_START_1;
         2'h2: boot_start = `FLCS_BOOT_START_2;
         2'h3: boot_start = `FLCS_BOOT_START_3;
      endcase
   end

   assign tgt_boot    = core_addr_in >= boot_start;
   assign pc_boot     = core_pc_in >= boot_start;
   assign store_block = tgt_boot & ~r_ff.lock[`FLCS_LK_BOOT_LOWER];
   assign load_block  = tgt_boot & ~pc_boot & ~r_ff.lock[`FLCS_LK_BOOT_UPPER];

   // ==================================================
   // next state
   always_comb begin
      nxt_r           = r_ff;
      nxt_r.store_ok  = 1'b0;
      nxt_r.store_ref = 1'b0;
      nxt_r.load_done = 1'b0;
      // core accesses
      if (core_store_req_in) begin
         nxt_r.store_ok  = ~store_block;
         nxt_r.store_ref = store_block;
      end
      if (core_load_req_in) begin
         nxt_r.load_done = 1'b1;
         nxt_r.load_data = load_block ? `FLCS_BLOCKED_DATA : mem_rdata_in;
      end
      nxt_r.irq_sup = ~r_ff.lock[`FLCS_LK_BOOT_UPPER] & vectors_in_app_in & pc_boot;
      // geometry
      nxt_r.fl_page = core_addr_in[`FLCS_PC_MSB:`FLCS_PC_PAGE_LSB];
      nxt_r.fl_word = core_addr_in[`FLCS_PC_WORD_MSB:0];
      nxt_r.ee_page = core_ee_addr_in[`FLCS_EE_MSB:`FLCS_EE_PAGE_LSB];
      nxt_r.ee_byte = core_ee_addr_in[`FLCS_EE_BYTE_MSB:0];
      // fuse working latches
      nxt_r.pm_d = pm;
      if ((pm != r_ff.pm_d) || r_ff.cap_pend) begin
         nxt_r.lat_fh   = r_ff.nv_fh;
         nxt_r.lat_fl   = r_ff.nv_fl;
         nxt_r.cap_pend = 1'b0;
      end
      nxt_r.eeprom_preserve_fuse = r_ff.lat_fh[`FLCS_FH_EEPROM_PRESERVE_FUSE] & r_ff.nv_fh[`FLCS_FH_EEPROM_PRESERVE_FUSE];
      if (osc_cal_wr_in) begin
         nxt_r.osc_cal = osc_cal_wdata_in;
      end
      // loads from the strobe pin
      if (pm && pin_rise[`FLCS_P_STROBE]) begin
         unique case ({pin_lvl[`FLCS_P_XA_HI], pin_lvl[`FLCS_P_XA_LO]})
            `FLCS_XA_ADDR: begin
               if (bs1) begin
                  nxt_r.addr_hi = pdata;
               end else begin
                  nxt_r.addr_lo = pdata;
               end
            end
            `FLCS_XA_DATA: begin
               if (bs1) begin
                  nxt_r.data_hi = pdata;
               end else begin
                  nxt_r.data_lo = pdata;
               end
            end
            `FLCS_XA_CMD: nxt_r.cmd = pdata;
            default: ;
         endcase
      end
      // busy countdown
      if (r_ff.pst == flcs_st_busy) begin
         if (r_ff.cnt == '0) begin
            nxt_r.pst = flcs_st_idle;
         end else begin
            nxt_r.cnt = r_ff.cnt - 1'b1;
         end
      end
      // write strobe runs the loaded command
      if (wr_go) begin
         nxt_r.cnt = PROG_CNT;
         unique case (r_ff.cmd)
            `FLCS_CMD_ERASE: begin
               nxt_r.lock = `FLCS_LOCK_RESET;
               nxt_r.cnt  = ERASE_CNT;
               nxt_r.pst  = flcs_st_busy;
            end
            `FLCS_CMD_WR_FUSE: begin
               if (r_ff.lock[`FLCS_LK_MEM_FIRST]) begin
                  nxt_r.pst = flcs_st_busy;
                  if (bs1) begin
                     nxt_r.nv_fh = pin_lvl[`FLCS_P_SERIAL]
                        ? (r_ff.data_lo & ~`FLCS_FH_SPROG_MASK)
                          | (r_ff.nv_fh & `FLCS_FH_SPROG_MASK)
                        : r_ff.data_lo;
                  end else begin
                     nxt_r.nv_fl = r_ff.data_lo;
                  end
               end
            end
            `FLCS_CMD_WR_LOCK: begin
               nxt_r.lock = r_ff.lock & r_ff.data_lo;
               nxt_r.pst  = flcs_st_busy;
            end
            `FLCS_CMD_WR_FLASH, `FLCS_CMD_WR_EE: nxt_r.pst = flcs_st_busy;
            default: ;
         endcase
      end
      // read strobe
      nxt_r.rd_oe   = pm & ~pin_lvl[`FLCS_P_OE_N];
      nxt_r.rd_data = `FLCS_PAD_BYTE;
      if (nxt_r.rd_oe) begin
         unique case (r_ff.cmd)
            `FLCS_CMD_RD_SIG: begin
               if (bs1) begin
                  unique case (r_ff.addr_lo[1:0])
                     2'h0: nxt_r.rd_data = CAL_1MHZ;
                     2'h1: nxt_r.rd_data = CAL_2MHZ;
                     2'h2: nxt_r.rd_data = CAL_4MHZ;
                     2'h3: nxt_r.rd_data = CAL_8MHZ;
                  endcase
               end else if (r_ff.addr_lo <= 8'(`FLCS_SIG_LAST)) begin
                  unique case (r_ff.addr_lo[1:0])
                     2'h0: nxt_r.rd_data = SIG_B0;
                     2'h1: nxt_r.rd_data = SIG_B1;
                     default: nxt_r.rd_data = SIG_B2;
                  endcase
               end
            end
            `FLCS_CMD_RD_FUSE: begin
               if (r_ff.addr_lo[0]) begin
                  nxt_r.rd_data = r_ff.lock;
               end else begin
                  nxt_r.rd_data = bs1 ? r_ff.nv_fh : r_ff.nv_fl;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         r_ff <= ST_RESET;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ==================================================
   // outputs
   assign store_grant_out              = r_ff.store_ok;
   assign store_refused_out            = r_ff.store_ref;
   assign load_done_out                = r_ff.load_done;
   assign load_data_out                = r_ff.load_data;
   assign irq_suppress_out             = r_ff.irq_sup;
   assign flash_page_out               = r_ff.fl_page;
   assign flash_word_out               = r_ff.fl_word;
   assign ee_page_out                  = r_ff.ee_page;
   assign ee_byte_out                  = r_ff.ee_byte;
   assign fuse_high_config_byte_out    = r_ff.lat_fh;
   assign fuse_low_config_byte_out     = r_ff.lat_fl;
   assign eeprom_preserve_out          = ~r_ff.eeprom_preserve_fuse;
   assign debug_clock_keep_out         = ~r_ff.lat_fh[`FLCS_FH_DEBUG];
   assign osc_calibration_register_out = r_ff.osc_cal;
   assign prog_data_out                = r_ff.rd_data;
   assign prog_data_oe_out             = r_ff.rd_oe;
   assign ready_busy_out               = (r_ff.pst == flcs_st_idle);

   // ==================================================
   // checks
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   chk_boot_store_refused: assert property (
      core_store_req_in && tgt_boot && !r_ff.lock[`FLCS_LK_BOOT_LOWER]
      |=> store_refused_out && !store_grant_out)
      else $error("boot store not refused");

   chk_app_store_granted: assert property (
      core_store_req_in && !tgt_boot |=> store_grant_out)
      else $error("application store not granted");

   chk_load_blocked_const: assert property (
      core_load_req_in && load_block
      |=> load_done_out && load_data_out == `FLCS_BLOCKED_DATA)
      else $error("blocked load leaked data");

   chk_load_pass_data: assert property (
      core_load_req_in && pc_boot |=> load_data_out == $past(mem_rdata_in))
      else $error("boot code load altered");

   chk_irq_boot_off: assert property (
      !r_ff.lock[`FLCS_LK_BOOT_UPPER] && vectors_in_app_in && pc_boot
      |=> irq_suppress_out)
      else $error("interrupts not suppressed in boot");

   chk_erase_keeps_fuses: assert property (
      wr_go && r_ff.cmd == `FLCS_CMD_ERASE
      |=> r_ff.nv_fh == $past(r_ff.nv_fh) && r_ff.nv_fl == $past(r_ff.nv_fl)
          && r_ff.lock == `FLCS_LOCK_RESET)
      else $error("erase disturbed fuses");

   chk_fuse_write_locked: assert property (
      wr_go && r_ff.cmd == `FLCS_CMD_WR_FUSE && !r_ff.lock[`FLCS_LK_MEM_FIRST]
      |=> r_ff.nv_fh == $past(r_ff.nv_fh) && r_ff.nv_fl == $past(r_ff.nv_fl))
      else $error("fuse write accepted while locked");

   chk_latch_holds: assert property (
      pm && r_ff.pm_d && !r_ff.cap_pend |=> $stable(r_ff.lat_fh) && $stable(r_ff.lat_fl))
      else $error("fuse latch changed inside programming mode");

   chk_busy_after_write: assert property (
      wr_go && r_ff.cmd == `FLCS_CMD_ERASE |=> !ready_busy_out [*8])
      else $error("ready during erase");

   chk_osc_reset_load: assert property (
      $past(rst_in) |-> osc_calibration_register_out == CAL_1MHZ)
      else $error("calibration not loaded at reset");

   cov_chip_erase: cover property (wr_go && r_ff.cmd == `FLCS_CMD_ERASE);
   cov_store_refused: cover property (store_refused_out);
   cov_load_blocked: cover property (core_load_req_in && load_block);
   cov_fuse_write: cover property (wr_go && r_ff.cmd == `FLCS_CMD_WR_FUSE);

endmodule : flcs_fuse_lock_store

//--- verif/flcs_prog_model.sv
module flcs_prog_model (
   // device status
   input  wire logic       ready_in,
   input  wire logic [7:0] data_in,
   // programmer pins
   output logic            strobe_out,
   output logic            xa_hi_out,
   output logic            xa_lo_out,
   output logic            bs1_out,
   output logic            wr_n_out,
   output logic            oe_n_out,
   output logic [7:0]      data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {strobe_out, xa_hi_out, xa_lo_out, bs1_out, wr_n_out, oe_n_out, data_out} = 14'h1bff;
   // selectors settle before the strobe and stay until it has fallen
   task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
      {xa_hi_out, xa_lo_out} = a;
      bs1_out = b;
      data_out = d;
      #80 strobe_out = 1'b1;
      #280 strobe_out = 1'b0;
      #120 {xa_hi_out, xa_lo_out} = 2'h3;
   endtask : load
   // n counts 40 ns steps spent busy after the pulse
   task automatic write(input logic b, output int n);
      bs1_out = b;
      n = 0;
      #80 wr_n_out = 1'b0;
      #280 wr_n_out = 1'b1;
      while (!ready_in && n < 400) #40 n++;
   endtask : write
   task automatic read(input logic b, output logic [7:0] d);
      bs1_out = b;
      #80 oe_n_out = 1'b0;
      #400 d = data_in;
      oe_n_out = 1'b1;
      #200;
   endtask : read
endmodule : flcs_prog_model

//--- verif/test_fuse_lock_config_store.sv
`include "flcs_consts.svh"
module test_fuse_lock_config_store;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_in, rst_in, core_store_req_in, core_load_req_in, vectors_in_app_in;
   logic        osc_cal_wr_in, prog_mode_in, serial_mode_in, load_strobe_pin_in, wr_n_in;
   logic        oe_n_in, action_select_hi_in, action_select_lo_in, byte_select_first_in;
   logic        store_grant_out, store_refused_out, load_done_out, irq_suppress_out;
   logic        eeprom_preserve_out, debug_clock_keep_out, prog_data_oe_out, ready_busy_out;
   logic [13:0] core_addr_in, core_pc_in;
   logic [15:0] mem_rdata_in, load_data_out;
   logic [9:0]  core_ee_addr_in;
   logic [7:0]  flash_page_out, ee_page_out, fuse_high_config_byte_out, fuse_low_config_byte_out;
   logic [7:0]  osc_cal_wdata_in, osc_calibration_register_out, prog_data_out, pm_data, rv;
   logic [5:0]  flash_word_out;
   logic [1:0]  ee_byte_out;
   wire  [7:0]  prog_data_in = prog_data_oe_out ? prog_data_out : pm_data;
   logic [7:0]  sig [3] = '{8'h4d, 8'h2e, 8'h07}; // arbitrary values
   int          failures = 0, check_count = 0, cyc = 0, w, seed, fh_m = 'h99, i;
   flcs_fuse_lock_store #(.SIG_B0(8'h4d), .SIG_B1(8'h2e), .SIG_B2(8'h07), .CAL_1MHZ(8'h6b))
      flcs_fuse_lock_store_inst (.*);
   flcs_prog_model flcs_prog_model_inst (.ready_in(ready_busy_out), .data_in(prog_data_in),
      .strobe_out(load_strobe_pin_in), .xa_hi_out(action_select_hi_in),
      .xa_lo_out(action_select_lo_in), .bs1_out(byte_select_first_in), .wr_n_out(wr_n_in),
      .oe_n_out(oe_n_in), .data_out(pm_data));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic core(input logic s, input logic [13:0] a, input logic [13:0] p);
      @(posedge clock_in);
      #2 {core_store_req_in, core_load_req_in, core_addr_in, core_pc_in} = {s, !s, a, p};
      mem_rdata_in = 16'($random(seed));
      @(posedge clock_in);
      #2 {core_store_req_in, core_load_req_in} = 2'h0;
   endtask : core
   task automatic op(input logic [7:0] c, input logic [7:0] d, input logic b);
      flcs_prog_model_inst.load(2'h2, 1'b0, c);
      flcs_prog_model_inst.load(2'h1, 1'b0, d);
      flcs_prog_model_inst.write(b, w);
   endtask : op
   task automatic rd(input logic [7:0] a, input logic b);
      flcs_prog_model_inst.load(2'h0, 1'b0, a);
      flcs_prog_model_inst.read(b, rv);
   endtask : rd
   task automatic end_sim;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_sim;
      end
   end
   initial begin
      seed = 32'h14e330bd;
      {rst_in, core_store_req_in, core_load_req_in, vectors_in_app_in, osc_cal_wr_in} = 5'h10;
      {prog_mode_in, serial_mode_in, core_addr_in, core_pc_in, mem_rdata_in} = '0;
      {core_ee_addr_in, osc_cal_wdata_in} = '0;
      repeat (6) @(posedge clock_in);
      #2 rst_in = 1'b0;
      @(posedge clock_in);
      #2 chk({fuse_high_config_byte_out, fuse_low_config_byte_out}, 16'h99e1);
      chk({osc_calibration_register_out, 7'h0, ready_busy_out}, 16'h6b01);
      osc_cal_wr_in = 1'b1;
      for (i = 0; i < 16; i++) begin
         {core_addr_in, core_ee_addr_in, osc_cal_wdata_in} = 32'($random(seed));
         @(posedge clock_in);
         #2 chk({flash_page_out, 2'h0, flash_word_out}, core_addr_in + (core_addr_in & 14'h3fc0) * 3);
         chk({ee_page_out, 6'h0, ee_byte_out}, core_ee_addr_in % 4 + core_ee_addr_in / 4 * 256);
         chk(osc_calibration_register_out, osc_cal_wdata_in);
      end
      osc_cal_wr_in = 1'b0;
      prog_mode_in = 1'b1;
      serial_mode_in = 1'b1;
      #400 op(`FLCS_CMD_WR_FUSE, 8'h31, 1'b1);
      serial_mode_in = 1'b0;
      chk(w > 60 && ready_busy_out === 1'b1, 1'b1);
      chk(fuse_high_config_byte_out, 16'(fh_m));
      fh_m = ('h31 & 'hdf) | (fh_m & 'h20);
      chk(eeprom_preserve_out, ((fh_m >> 3) & 1) == 0);
      flcs_prog_model_inst.load(2'h2, 1'b0, `FLCS_CMD_RD_FUSE);
      rd(8'h00, 1'b1);
      chk(rv, 16'(fh_m));
      prog_mode_in = 1'b0;
      #400 chk(fuse_high_config_byte_out, 16'(fh_m));
      chk(debug_clock_keep_out, ((fh_m >> 7) & 1) == 0);
      for (i = 0; i < 4; i++) begin
         prog_mode_in = 1'b1;
         #400 op(`FLCS_CMD_ERASE, 8'hff, 1'b0);
         chk(fuse_high_config_byte_out, 16'(fh_m));
         op(`FLCS_CMD_WR_LOCK, 8'('hcf | i << 4), 1'b0);
         prog_mode_in = 1'b0;
         #400 core(1'b1, 14'h3000, 14'h0100);
         chk({store_refused_out, store_grant_out}, (i & 1) ? 2'h1 : 2'h2);
         core(1'b0, 14'h3000, 14'h0100);
         chk(load_data_out, (i & 2) ? mem_rdata_in : 16'hffff);
         vectors_in_app_in = 1'b1;
         core(1'b0, 14'h3000, 14'h3100);
         chk({load_done_out, load_data_out}, {1'b1, mem_rdata_in});
         chk(irq_suppress_out, (i & 2) == 0);
         vectors_in_app_in = 1'b0;
      end
      prog_mode_in = 1'b1;
      #400 op(`FLCS_CMD_WR_LOCK, 8'hfe, 1'b0);
      op(`FLCS_CMD_WR_FUSE, 8'h00, 1'b0);
      chk(w, 0);
      flcs_prog_model_inst.load(2'h2, 1'b0, `FLCS_CMD_RD_SIG);
      for (i = 0; i < 3; i++) begin
         rd(8'(i), 1'b0);
         chk(rv, sig[i]);
      end
      rd(8'h00, 1'b1);
      chk(rv, 8'h6b);
      prog_mode_in = 1'b0;
      #400 chk(fuse_low_config_byte_out, 8'he1);
      end_sim;
   end
endmodule : test_fuse_lock_config_store
